/* File: verilog/tmw_timer8.sv */
// What this block does
// - counter moves only on clock cycles where the timer tick enable is high or the count register is written
// - nonzero output mode overrides the pin, but PWM toggle code without its enabling bit disconnects it; drive only when direction is output
// - non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match
// - non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match
// - PWM channel A mode 01 toggles on match only when high mode bit set
// - phase PWM channel A: 10 clear up-match set down-match, 11 inverse
// - fast PWM channel B: 10 and 11 like channel A, 01 reserved
// - phase PWM channel B: 10 and 11 like channel A, 01 reserved
// - PWM with compare equal top and upper mode bit: skip match, act at top
// - control register A bits 3 and 2 read as zero
// - three-bit mode selects normal, phase, clear-on-match, fast; 4 and 6 reserved
// - clear-on-match and mode 7 clear counter on A match; flags set on match
// - fast PWM counts to top then returns to zero next tick
// - phase PWM counts up to top, shows top one tick, then counts down
`timescale 1ns/1ps
module tmw_timer8
  import tmw_pkg::*;
(
  input  wire logic                 clk_i,         // 250 MHz i/o clock
  input  wire logic                 rst_i,         // sync reset, active high
  input  wire logic                 tick_i,        // timer tick enable from prescaler
  input  wire tmw_pkg::tmw_wb_req_s wb_i,          // wishbone request
  output logic                      wb_ack_o,      // wishbone ack
  output logic [31:0]               wb_dat_o,      // wishbone read data
  output logic                      wave_out_a_o,  // waveform a pin value
  output logic                      wave_oe_a_o,   // waveform a pin enable
  output logic                      wave_out_b_o,  // waveform b pin value
  output logic                      wave_oe_b_o,   // waveform b pin enable
  output logic                      irq_o          // level interrupt
);
  import tmw_pkg::*;

  logic [7:0] ctrl_a_reg;
  logic       wave_high_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       dir_up_reg;
  logic       dir_up_next;
  logic [7:0] cmp_a_buf_reg;
  logic [7:0] cmp_b_buf_reg;
  logic [7:0] cmp_a_act_reg;
  logic [7:0] cmp_b_act_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [1:0] pin_dir_reg;
  logic       block_reg;
  logic       ack_reg;
  logic [31:0] rdat_reg;
  logic [1:0] wave_reg;
  logic [1:0] wave_next;
  logic [1:0] oe_reg;
  logic       irq_reg;

  // bus decode
  wire        bus_req  = wb_i.cyc & wb_i.stb & ~ack_reg;
  wire        bus_wr   = bus_req & wb_i.we & wb_i.sel[0];
  // irq uses the mask value that this edge stores, so it tracks flags and mask together
  wire [2:0]  mask_next;
  wire [7:0]  wdat     = wb_i.dat[7:0];
  wire        wr_ctl_a = bus_wr & (wb_i.adr == OFF_CTRL_A);
  wire        wr_ctl_b = bus_wr & (wb_i.adr == OFF_CTRL_B);
  wire        wr_cnt   = bus_wr & (wb_i.adr == OFF_COUNT);
  wire        wr_cmp_a = bus_wr & (wb_i.adr == OFF_CMP_A);
  wire        wr_cmp_b = bus_wr & (wb_i.adr == OFF_CMP_B);
  wire        wr_stat  = bus_wr & (wb_i.adr == OFF_STATUS);
  wire        wr_mask  = bus_wr & (wb_i.adr == OFF_MASK);
  wire        wr_dir   = bus_wr & (wb_i.adr == OFF_PIN_DIR);
  assign mask_next = wr_mask ? wdat[2:0] : mask_reg;

  wire [1:0]  out_a_mode    = ctrl_a_reg[OUT_A_HI:OUT_A_LO];
  wire [1:0]  out_b_mode    = ctrl_a_reg[OUT_B_HI:OUT_B_LO];
  wire [1:0]  wave_mode_low = ctrl_a_reg[WAVE_LOW_HI:WAVE_LOW_LO];
  wire [2:0]  wave_mode     = {wave_high_reg, wave_mode_low};

  // mode decode
  tmw_kind_e kind;
  assign kind = (wave_mode == WM_NORMAL)     ? KIND_NORMAL :
                (wave_mode == WM_CTC)        ? KIND_CTC :
                (wave_mode == WM_FAST_FF)    ? KIND_FAST :
                (wave_mode == WM_FAST_CMPA)  ? KIND_FAST :
                (wave_mode == WM_PHASE_FF)   ? KIND_PHASE :
                (wave_mode == WM_PHASE_CMPA) ? KIND_PHASE : KIND_RSVD;
  wire        is_pwm   = (kind == KIND_FAST) | (kind == KIND_PHASE);
  wire        top_cmpa = (wave_mode == WM_CTC) | (wave_mode == WM_PHASE_CMPA)
                       | (wave_mode == WM_FAST_CMPA);
  wire [7:0]  top_val  = top_cmpa ? cmp_a_act_reg : CNT_MAX;
  wire        at_top   = cnt_reg == top_val;
  wire        tick_top = tick_i & at_top;
  wire        upd_cmp  = tick_top & is_pwm;
  // a counter write removes the compare match on the next tick
  wire        m_a      = tick_i & ~block_reg & (cnt_reg == cmp_a_act_reg);
  wire        m_b      = tick_i & ~block_reg & (cnt_reg == cmp_b_act_reg);
  wire        ovf_max  = (kind == KIND_NORMAL) | (kind == KIND_CTC) | (kind == KIND_RSVD)
                       | (wave_mode == WM_FAST_FF);
  wire        ovf_ev   = tick_i & ((ovf_max & (cnt_reg == CNT_MAX))
                       | ((kind == KIND_PHASE) & (cnt_reg == CNT_BOTTOM))
                       | ((wave_mode == WM_FAST_CMPA) & at_top));

  // counter sequencing
  always_comb
  begin
    cnt_next    = cnt_reg;
    dir_up_next = dir_up_reg;
    if (wr_cnt)
    begin
      cnt_next = wdat;
    end
    else if (tick_i)
    begin
      case (kind)
        KIND_PHASE:
        begin
          if (dir_up_reg & (cnt_reg < top_val))
          begin
            cnt_next = cnt_reg + CNT_ONE;
          end
          else if (dir_up_reg)
          begin
            dir_up_next = 1'b0;
            cnt_next    = (cnt_reg == CNT_BOTTOM) ? CNT_BOTTOM : cnt_reg - CNT_ONE;
          end
          else if (cnt_reg == CNT_BOTTOM)
          begin
            dir_up_next = 1'b1;
            cnt_next    = (top_val == CNT_BOTTOM) ? CNT_BOTTOM : CNT_ONE;
          end
          else
          begin
            cnt_next = cnt_reg - CNT_ONE;
          end
        end
        KIND_CTC, KIND_FAST: cnt_next = at_top ? CNT_BOTTOM : cnt_reg + CNT_ONE;
        default: cnt_next = cnt_reg + CNT_ONE;
      endcase
    end
  end

  // hardware set wins over software write-one clear
  assign status_next = (status_reg & ~(wr_stat ? wdat[2:0] : 3'h0))
                     | {m_b, m_a, ovf_ev};

  // per-channel waveform generation
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      wire [1:0] om      = (ch == 0) ? out_a_mode : out_b_mode;
      wire [7:0] cmp     = (ch == 0) ? cmp_a_act_reg : cmp_b_act_reg;
      wire       mt      = (ch == 0) ? m_a : m_b;
      // channel b has no toggle in PWM modes
      wire       tog_ok  = (ch == 0) & wave_high_reg;
      wire       cmp_top = cmp == top_val;
      wire       use_mt  = mt & ~(om[1] & cmp_top);
      // toggle code without its enabling mode bit leaves the pin disconnected in PWM
      wire       pin_off = is_pwm & (om == OM_TOGGLE) & ~tog_ok;
      always_comb
      begin
        wave_next[ch] = wave_reg[ch];
        case (kind)
          KIND_NORMAL, KIND_CTC:
          begin
            if (mt)
            begin
              case (om)
                OM_TOGGLE: wave_next[ch] = ~wave_reg[ch];
                OM_CLEAR:  wave_next[ch] = 1'b0;
                OM_SET:    wave_next[ch] = 1'b1;
                default:   wave_next[ch] = wave_reg[ch];
              endcase
            end
          end
          KIND_FAST:
          begin
            if ((om == OM_TOGGLE) & tog_ok & mt)
            begin
              wave_next[ch] = ~wave_reg[ch];
            end
            else if (om[1] & use_mt)
            begin
              wave_next[ch] = om[0];
            end
            else if (om[1] & tick_top)
            begin
              wave_next[ch] = ~om[0];
            end
          end
          KIND_PHASE:
          begin
            if ((om == OM_TOGGLE) & tog_ok & mt)
            begin
              wave_next[ch] = ~wave_reg[ch];
            end
            else if (om[1] & use_mt)
            begin
              wave_next[ch] = dir_up_reg ? om[0] : ~om[0];
            end
            else if (om[1] & cmp_top & tick_top & dir_up_reg)
            begin
              wave_next[ch] = ~om[0];
            end
          end
          default: wave_next[ch] = wave_reg[ch];
        endcase
      end
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          wave_reg[ch] <= 1'b0;
          oe_reg[ch]   <= 1'b0;
        end
        else
        begin
          wave_reg[ch] <= wave_next[ch];
          oe_reg[ch]   <= (|om) & ~pin_off & pin_dir_reg[ch];
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero
  wire [7:0] rd_byte =
      (wb_i.adr == OFF_CTRL_A)  ? (ctrl_a_reg & CTRL_A_WMASK) :
      (wb_i.adr == OFF_CTRL_B)  ? {4'h0, wave_high_reg, 3'h0} :
      (wb_i.adr == OFF_COUNT)   ? cnt_reg :
      (wb_i.adr == OFF_CMP_A)   ? cmp_a_buf_reg :
      (wb_i.adr == OFF_CMP_B)   ? cmp_b_buf_reg :
      (wb_i.adr == OFF_STATUS)  ? {5'h00, status_reg} :
      (wb_i.adr == OFF_MASK)    ? {5'h00, mask_reg} :
      (wb_i.adr == OFF_PIN_DIR) ? {6'h00, pin_dir_reg} : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_a_reg    <= CTRL_A_RESET;
      wave_high_reg <= 1'b0;
      cnt_reg       <= CNT_BOTTOM;
      dir_up_reg    <= 1'b1;
      block_reg     <= 1'b0;
      status_reg    <= FLAGS_RESET;
      mask_reg      <= FLAGS_RESET;
      pin_dir_reg   <= DIR_RESET;
      ack_reg       <= 1'b0;
      rdat_reg      <= 32'h0000_0000;
      irq_reg       <= 1'b0;
    end
    else
    begin
      ack_reg    <= bus_req;
      rdat_reg   <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      cnt_reg    <= cnt_next;
      dir_up_reg <= (kind == KIND_PHASE) ? dir_up_next : 1'b1;
      block_reg  <= wr_cnt | (block_reg & ~tick_i);
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_next);
      if (wr_ctl_a)
      begin
        ctrl_a_reg <= wdat & CTRL_A_WMASK;
      end
      if (wr_ctl_b)
      begin
        wave_high_reg <= wdat[WAVE_HIGH_BIT];
      end
      mask_reg <= mask_next;
      if (wr_dir)
      begin
        pin_dir_reg <= wdat[1:0];
      end
    end
  end

  // compare buffers: direct in non-PWM, transferred at top in PWM
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmp_a_buf_reg <= CNT_BOTTOM;
      cmp_b_buf_reg <= CNT_BOTTOM;
      cmp_a_act_reg <= CNT_BOTTOM;
      cmp_b_act_reg <= CNT_BOTTOM;
    end
    else
    begin
      if (wr_cmp_a)
      begin
        cmp_a_buf_reg <= wdat;
      end
      if (wr_cmp_b)
      begin
        cmp_b_buf_reg <= wdat;
      end
      if (!is_pwm)
      begin
        cmp_a_act_reg <= wr_cmp_a ? wdat : cmp_a_buf_reg;
        cmp_b_act_reg <= wr_cmp_b ? wdat : cmp_b_buf_reg;
      end
      else if (upd_cmp)
      begin
        cmp_a_act_reg <= cmp_a_buf_reg;
        cmp_b_act_reg <= cmp_b_buf_reg;
      end
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = rdat_reg;
  assign wave_out_a_o = wave_reg[0];
  assign wave_out_b_o = wave_reg[1];
  assign wave_oe_a_o  = oe_reg[0];
  assign wave_oe_b_o  = oe_reg[1];
  assign irq_o        = irq_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_phase_top;
    (kind == KIND_PHASE) & tick_i & dir_up_reg & at_top & (cnt_reg != CNT_BOTTOM) & ~wr_cnt;
  endsequence
  sequence s_phase_down;
    ~dir_up_reg & (cnt_reg == $past(cnt_reg) - CNT_ONE);
  endsequence

  a_tick_gate: assert property (~tick_i & ~wr_cnt |=> $stable(cnt_reg))
    else $error("counter moved without a tick");
  a_pin_off: assert property ((out_a_mode == OM_OFF) |=> ~wave_oe_a_o)
    else $error("pin a driven while output mode is off");
  a_ctc_toggle: assert property ((kind == KIND_CTC) & m_a & (out_a_mode == OM_TOGGLE)
      |=> wave_out_a_o != $past(wave_out_a_o))
    else $error("channel a did not toggle on match");
  a_ctrl_a_resv: assert property (bus_req & ~wb_i.we & (wb_i.adr == OFF_CTRL_A)
      |=> wb_ack_o & (wb_dat_o[3:2] == 2'h0))
    else $error("control a reserved bits not zero");
  a_cmp_buffered: assert property (is_pwm & ~upd_cmp
      |=> $stable(cmp_a_act_reg))
    else $error("active compare changed away from top");
  a_ovf_phase: assert property ((kind == KIND_PHASE) & tick_i & (cnt_reg == CNT_BOTTOM)
      |=> status_reg[ST_OVF])
    else $error("overflow flag missing at bottom");
  a_ctc_clear: assert property ((kind == KIND_CTC) & m_a & ~wr_cnt
      |=> (cnt_reg == CNT_BOTTOM) & status_reg[ST_MATCH_A])
    else $error("clear-on-match did not clear counter");
  a_match_b_flag: assert property (m_b |=> status_reg[ST_MATCH_B])
    else $error("match b flag not set");
  a_fast_wrap: assert property ((kind == KIND_FAST) & tick_top & ~wr_cnt
      |=> cnt_reg == CNT_BOTTOM)
    else $error("fast mode did not wrap at top");
  a_phase_turn: assert property (s_phase_top |=> s_phase_down)
    else $error("phase mode did not turn at top");
  a_irq_level: assert property (|(status_reg & mask_reg) |-> irq_o)
    else $error("interrupt low with unmasked flag");
endmodule

/* File: verilog/tmw_pkg.sv */
package tmw_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL_A  = 8'h24;
  localparam logic [7:0] OFF_CTRL_B  = 8'h28;
  localparam logic [7:0] OFF_COUNT   = 8'h2c;
  localparam logic [7:0] OFF_CMP_A   = 8'h30;
  localparam logic [7:0] OFF_CMP_B   = 8'h34;
  localparam logic [7:0] OFF_STATUS  = 8'h38;
  localparam logic [7:0] OFF_MASK    = 8'h3c;
  localparam logic [7:0] OFF_PIN_DIR = 8'h40;
  // field positions
  localparam int OUT_A_HI      = 7;
  localparam int OUT_A_LO      = 6;
  localparam int OUT_B_HI      = 5;
  localparam int OUT_B_LO      = 4;
  localparam int WAVE_LOW_HI   = 1;
  localparam int WAVE_LOW_LO   = 0;
  localparam int WAVE_HIGH_BIT = 3;
  localparam int ST_OVF        = 0;
  localparam int ST_MATCH_A    = 1;
  localparam int ST_MATCH_B    = 2;
  // reset values and masks
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [2:0] FLAGS_RESET  = 3'h0;
  localparam logic [1:0] DIR_RESET    = 2'h0;
  // waveform mode codes
  localparam logic [2:0] WM_NORMAL     = 3'h0;
  localparam logic [2:0] WM_PHASE_FF   = 3'h1;
  localparam logic [2:0] WM_CTC        = 3'h2;
  localparam logic [2:0] WM_FAST_FF    = 3'h3;
  localparam logic [2:0] WM_PHASE_CMPA = 3'h5;
  localparam logic [2:0] WM_FAST_CMPA  = 3'h7;
  // output mode codes
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;

  typedef enum logic [2:0] {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PHASE, KIND_RSVD} tmw_kind_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tmw_wb_req_s;
endpackage

/* File: verif/tmw_timer8_tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tmw_timer8_tb_top;
  import tmw_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        tick_i;
  tmw_wb_req_s wb_i;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic        wave_out_a_o;
  logic        wave_oe_a_o;
  logic        wave_out_b_o;
  logic        wave_oe_b_o;
  logic        irq_o;
  int          err_total;
  int          check_count;
  integer      seed;
  logic [31:0] rd;
  logic [7:0]  val;

  tmw_timer8 tmw_timer8_inst (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (tick_i),
    .wb_i         (wb_i),
    .wb_ack_o     (wb_ack_o),
    .wb_dat_o     (wb_dat_o),
    .wave_out_a_o (wave_out_a_o),
    .wave_oe_a_o  (wave_oe_a_o),
    .wave_out_b_o (wave_out_b_o),
    .wave_oe_b_o  (wave_oe_b_o),
    .irq_o        (irq_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // control a reads back with its two unused bits forced low
  function automatic logic [7:0] ctrl_a_exp(input logic [7:0] w);
    return {w[7:4], 2'b00, w[1:0]};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, dat}};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
    begin
      err_total++;
      conclude();
    end
    rd = wb_dat_o;
    wb_i <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rc(input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    `CHK(rd, {24'h0, exp})
  endtask

  // random idle gaps between ticks: the counter must ignore them
  task automatic ticks(input int n);
    repeat (n)
    begin
      repeat ($unsigned($random(seed)) % 3) @(posedge clk_i);
      @(posedge clk_i);
      tick_i <= 1'b1;
      @(posedge clk_i);
      tick_i <= 1'b0;
    end
  endtask

  // order: oe a, out a, oe b, out b
  task automatic wv(input logic [3:0] exp);
    @(negedge clk_i);
    `CHK({wave_oe_a_o, wave_out_a_o, wave_oe_b_o, wave_out_b_o}, exp)
  endtask

  initial
  begin
    #200000;
    err_total++;
    conclude();
  end

  initial
  begin
    seed = 32'h995758f7;
    err_total = 0;
    check_count = 0;
    rst_i = 1'b1;
    tick_i = 1'b0;
    wb_i = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(OFF_CTRL_A, CTRL_A_RESET);
    rc(OFF_STATUS, 8'h00);
    wr(OFF_CTRL_A, 8'hff);
    rc(OFF_CTRL_A, ctrl_a_exp(8'hff));
    wr(8'h10, 8'h5a);
    rc(8'h10, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      val = 8'($random(seed));
      wr(OFF_CMP_B, val);
      rc(OFF_CMP_B, val);
    end
    // mode 7, top from compare a, loaded while still in normal mode
    wr(OFF_CTRL_A, 8'h00);
    wr(OFF_CMP_A, 8'h05);
    wr(OFF_CMP_B, 8'h03);
    wr(OFF_COUNT, 8'h00);
    wr(OFF_CTRL_B, 8'h08);
    wr(OFF_CTRL_A, 8'h03);
    wr(OFF_STATUS, 8'h07);
    ticks(5);
    rc(OFF_COUNT, 8'h05);
    rc(OFF_STATUS, 8'h04);
    ticks(1);
    rc(OFF_COUNT, 8'h00);
    rc(OFF_STATUS, 8'h07);
    `CHK(irq_o, 1'b0)
    wr(OFF_MASK, 8'h04);
    @(negedge clk_i);
    `CHK(irq_o, 1'b1)
    wr(OFF_STATUS, 8'h04);
    @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    rc(OFF_STATUS, 8'h03);
    wr(OFF_MASK, 8'h00);
    // pwm compare write waits for top
    wr(OFF_CMP_A, 8'h09);
    rc(OFF_CMP_A, 8'h09);
    ticks(6);
    rc(OFF_COUNT, 8'h00);
    ticks(6);
    rc(OFF_COUNT, 8'h06);
    // clear-on-match: a toggles, b sets
    wr(OFF_CTRL_B, 8'h00);
    wr(OFF_CTRL_A, 8'h72);
    wr(OFF_CMP_A, 8'h04);
    wr(OFF_CMP_B, 8'h02);
    wr(OFF_PIN_DIR, 8'h03);
    wr(OFF_COUNT, 8'h00);
    ticks(5);
    wv(4'b1111);
    rc(OFF_COUNT, 8'h00);
    ticks(5);
    wv(4'b1011);
    wr(OFF_CTRL_A, 8'h62);
    ticks(5);
    wv(4'b1110);
    wr(OFF_PIN_DIR, 8'h01);
    @(negedge clk_i);
    `CHK(wave_oe_b_o, 1'b0)
    wr(OFF_CTRL_A, 8'h22);
    @(negedge clk_i);
    `CHK(wave_oe_a_o, 1'b0)
    // fast pwm, top 0xff: a inverted, b non-inverted
    wr(OFF_PIN_DIR, 8'h03);
    wr(OFF_CTRL_A, 8'he3);
    wr(OFF_CMP_A, 8'h02);
    wr(OFF_CMP_B, 8'h01);
    wr(OFF_COUNT, 8'hfe);
    wr(OFF_STATUS, 8'h07);
    ticks(2);
    wv(4'b1011);
    rc(OFF_STATUS, 8'h01);
    ticks(3);
    wv(4'b1110);
    // phase pwm, top = compare a = 2, a inverted hits the top case
    wr(OFF_CTRL_B, 8'h08);
    wr(OFF_CTRL_A, 8'hf1);
    wr(OFF_COUNT, 8'h00);
    ticks(2);
    wv(4'b1111);
    rc(OFF_COUNT, 8'h02);
    ticks(1);
    wv(4'b1011);
    rc(OFF_COUNT, 8'h01);
    wr(OFF_STATUS, 8'h07);
    ticks(1);
    wv(4'b1010);
    ticks(1);
    rc(OFF_COUNT, 8'h01);
    rc(OFF_STATUS, 8'h05);
    // reserved mode 4: plain counting, waveforms frozen
    wr(OFF_CTRL_A, 8'hf0);
    wr(OFF_COUNT, 8'hfe);
    wr(OFF_STATUS, 8'h07);
    ticks(2);
    wv(4'b1010);
    rc(OFF_COUNT, 8'h00);
    rc(OFF_STATUS, 8'h01);
    // toggle of a in pwm only with the high mode bit
    wr(OFF_CTRL_A, 8'h43);
    wr(OFF_CTRL_B, 8'h08);
    wr(OFF_COUNT, 8'h00);
    ticks(3);
    wv(4'b1100);
    wr(OFF_CTRL_B, 8'h00);
    @(negedge clk_i);
    `CHK(wave_oe_a_o, 1'b0)
    conclude();
  end
endmodule
